// ### common/scrb_access_if.sv
// Internal access path from the port arbiter to the register bank
`timescale 1ns/1ps
`include "scrb_defines.svh"
interface scrb_access_if;
  logic valid;
  logic write;
  logic [`SCRB_ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport arbiter (output valid, output write, output addr, output wdata,
    input rdata);
  modport bank (input valid, input write, input addr, input wdata,
    output rdata);
endinterface : scrb_access_if

// ### common/scrb_defines.svh
// Offsets, field masks, bit positions and counts for the system register bank
`ifndef SCRB_DEFINES_SVH
`define SCRB_DEFINES_SVH

`define SCRB_ADDR_W 10
`define SCRB_NREG 34

`define SCRB_OFF_CHIP_IDENTITY_REVISION 10'h050
`define SCRB_OFF_IRQ_CFG 10'h054
`define SCRB_OFF_INTERRUPT_STATUS 10'h058
`define SCRB_OFF_INT_EN 10'h05C
`define SCRB_OFF_BYTE_TEST 10'h064
`define SCRB_OFF_HARDWARE_CONFIG 10'h074
`define SCRB_OFF_GP_TIMER_CONFIG 10'h08C
`define SCRB_OFF_GP_TIMER_COUNT 10'h090
`define SCRB_OFF_FREE_RUN 10'h09C
`define SCRB_OFF_PMGMT_DATA 10'h0A4
`define SCRB_OFF_PMGMT_ACC 10'h0A8
`define SCRB_OFF_FC1 10'h1A0
`define SCRB_OFF_FC2 10'h1A4
`define SCRB_OFF_FC0 10'h1A8
`define SCRB_OFF_FAB_DATA 10'h1AC
`define SCRB_OFF_FAB_CMD 10'h1B0
`define SCRB_OFF_ROM_CMD 10'h1B4
`define SCRB_OFF_ROM_DATA 10'h1B8
`define SCRB_OFF_IND_CFG 10'h1BC
`define SCRB_OFF_EPHY_CTRL 10'h1C0
`define SCRB_OFF_EPHY_STAT 10'h1C4
`define SCRB_OFF_EPHY_IDH 10'h1C8
`define SCRB_OFF_EPHY_IDL 10'h1CC
`define SCRB_OFF_EPHY_ADV 10'h1D0
`define SCRB_OFF_EPHY_LPA 10'h1D4
`define SCRB_OFF_EPHY_EXP 10'h1D8
`define SCRB_OFF_EPHY_SPC 10'h1DC
`define SCRB_OFF_GIO_CFG 10'h1E0
`define SCRB_OFF_GIO_DIR 10'h1E4
`define SCRB_OFF_GIO_EVT 10'h1E8
`define SCRB_OFF_P1_CTRL 10'h1EC
`define SCRB_OFF_STA_HI 10'h1F0
`define SCRB_OFF_STA_LO 10'h1F4
`define SCRB_OFF_RESET_CONTROL 10'h1F8
`define SCRB_WIN_LO 10'h200
`define SCRB_WIN_HI 10'h2DC

`define SCRB_ALL 32'hFFFF_FFFF
`define SCRB_NONE 32'h0000_0000
`define SCRB_IRQCFG_RW 32'hFF00_0111
`define SCRB_IRQCFG_SC 32'h0000_4000
`define SCRB_IRQCFG_RO 32'h0000_3000
`define SCRB_IRQCFG_SOFT_RESET_IMMUNE 32'h0000_0011
`define SCRB_IRQ_EN_BIT 8
`define SCRB_IRQ_POL_BIT 4
`define SCRB_IRQ_TYPE_BIT 0
`define SCRB_IRQ_MASTER_BIT 12
`define SCRB_IRQ_DEAS_STS_BIT 13
`define SCRB_IRQ_DEAS_CLR_BIT 14
`define SCRB_IRQ_DEAS_LSB 24
`define SCRB_BIT15 32'h0000_8000
`define SCRB_BIT0 32'h0000_0001
`define SCRB_BIT31 32'h8000_0000
`define SCRB_LOW15 32'h0000_7FFF
`define SCRB_LOW31 32'h7FFF_FFFF
`define SCRB_EPHY_LINK_BIT 2
`define SCRB_EPHY_FAULT_BIT 4
`define SCRB_EPHY_STAT_LL 32'h0000_0004
`define SCRB_EPHY_STAT_ROLH 32'h0000_0010
`define SCRB_EPHY_EXP_RC 32'h0000_0001
`define SCRB_EPHY_EXP_LH 32'h0000_0002
`define SCRB_GIO_EVT_WAC 32'h0000_0FFF
`define SCRB_GIO_EVT_RW 32'h0FFF_0000
`define SCRB_RSTCTL_SOFT_BIT 0

`endif

// ### common/scrb_pkg.sv
// Types shared by the system register bank
package scrb_pkg;

  // Per-bit behaviour masks of one register word
  typedef struct packed {
    logic [31:0] rstVal;
    logic [31:0] rw;
    logic [31:0] ro;
    logic [31:0] write_any_clear;
    logic [31:0] woc;
    logic [31:0] rc;
    logic [31:0] ll;
    logic [31:0] lh;
    logic [31:0] sc;
    logic [31:0] ss;
    logic [31:0] rolh;
    logic [31:0] soft_reset_immune;
  } scrb_attr_t;

  typedef enum {SCRB_SRC_NONE, SCRB_SRC_I2C, SCRB_SRC_SMI} scrb_src_t;

endpackage : scrb_pkg

// ### hw/scrb_access_arbiter.sv
// Merges the two serial management access ports onto the bank
`timescale 1ns/1ps
`include "scrb_defines.svh"
module scrb_access_arbiter (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic i2cReq,
  input wire logic i2cWrite,
  input wire logic [`SCRB_ADDR_W-1:0] i2cAddr,
  input wire logic [31:0] i2cWdata,
  output logic i2cAck,
  output logic [31:0] i2cRdata,
  input wire logic smiReq,
  input wire logic smiWrite,
  input wire logic [`SCRB_ADDR_W-1:0] smiAddr,
  input wire logic [31:0] smiWdata,
  output logic smiAck,
  output logic [31:0] smiRdata,
  scrb_access_if.arbiter bus
);
  scrb_pkg::scrb_src_t ackSrc;
  scrb_pkg::scrb_src_t next_ackSrc;

  // A port in its ack cycle is not taken again
  wire takeI2c = i2cReq && (ackSrc != scrb_pkg::SCRB_SRC_I2C);
  wire takeSmi = smiReq && (ackSrc != scrb_pkg::SCRB_SRC_SMI) && !takeI2c;

  assign bus.valid = takeI2c || takeSmi;
  assign bus.write = takeI2c ? i2cWrite : smiWrite;
  assign bus.addr = takeI2c ? i2cAddr : smiAddr;
  assign bus.wdata = takeI2c ? i2cWdata : smiWdata;
  assign next_ackSrc = takeI2c ? scrb_pkg::SCRB_SRC_I2C :
                       takeSmi ? scrb_pkg::SCRB_SRC_SMI :
                       scrb_pkg::SCRB_SRC_NONE;
  assign i2cAck = (ackSrc == scrb_pkg::SCRB_SRC_I2C);
  assign smiAck = (ackSrc == scrb_pkg::SCRB_SRC_SMI);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ackSrc <= scrb_pkg::SCRB_SRC_NONE;
    else
      ackSrc <= next_ackSrc;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      i2cRdata <= 32'h0000_0000;
      smiRdata <= 32'h0000_0000;
    end
    else
    begin
      if (takeI2c)
        i2cRdata <= bus.rdata;
      if (takeSmi)
        smiRdata <= bus.rdata;
    end
  end
endmodule : scrb_access_arbiter

// ### hw/scrb_reg_cell.sv
// One register word whose bits follow their attribute masks
`timescale 1ns/1ps
`include "scrb_defines.svh"
module scrb_reg_cell #(
  parameter scrb_pkg::scrb_attr_t ATTR = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic swReset,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [31:0] wdata,
  input wire logic [31:0] hwIn,
  output logic [31:0] value
);
  if ((ATTR.rw & (ATTR.ro | ATTR.rolh | ATTR.ll | ATTR.rc)) != 32'h0)
  begin : g_bad_attr
    $error("scrb_reg_cell: writable bit also marked read-only");
  end

  wire [31:0] wMask = wrEn ? `SCRB_ALL : `SCRB_NONE;
  wire [31:0] rMask = rdEn ? `SCRB_ALL : `SCRB_NONE;
  // Plain storage and mirrored inputs
  wire [31:0] vRw = (value & ~(ATTR.rw & wMask)) | (wdata & ATTR.rw & wMask);
  wire [31:0] vRo = (vRw & ~ATTR.ro) | (hwIn & ATTR.ro);
  // Clears by write and by read
  wire [31:0] vWac = vRo & ~(ATTR.write_any_clear & wMask);
  wire [31:0] vWoc = vWac & ~(ATTR.woc & wdata & wMask);
  wire [31:0] vRc = vWoc & ~((ATTR.rc | ATTR.lh) & rMask);
  // Self clearing and self setting
  wire [31:0] vSc = (vRc & ~ATTR.sc) | (ATTR.sc & wdata & wMask);
  wire [31:0] vSs = (vSc | ATTR.ss) & ~(ATTR.ss & ~wdata & wMask);
  // Latch low: hold a captured low until read
  wire [31:0] llRead = (vSs & ~ATTR.ll) | (hwIn & ATTR.ll);
  wire [31:0] llHold = vSs & ~(ATTR.ll & ~hwIn);
  wire [31:0] vLl = rdEn ? llRead : llHold;
  // Sticky high until read, then follow the condition
  wire [31:0] rhRead = (vLl & ~ATTR.rolh) | (hwIn & ATTR.rolh);
  wire [31:0] vRolh = rdEn ? rhRead : (vLl | (hwIn & ATTR.rolh));
  // Hardware events set last so a set beats a same-cycle clear
  wire [31:0] evMask = ATTR.write_any_clear | ATTR.woc | ATTR.rc | ATTR.lh;
  wire [31:0] vSet = vRolh | (hwIn & evMask);
  wire [31:0] softVal = (ATTR.rstVal & ~ATTR.soft_reset_immune) | (vSet & ATTR.soft_reset_immune);
  wire [31:0] next_value = swReset ? softVal : vSet;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      value <= ATTR.rstVal;
    else
      value <= next_value;
  end
endmodule : scrb_reg_cell

// ### hw/scrb_system_csr_bank.sv
// System control and status register bank behind the management ports
//
// Notes on behaviour
// - Write-any-clear bits go to zero on any write, whatever the data.
// - Read-clear bits zero after a completed read; writes leave them.
// - Latch-low and latch-high bits hold captures until their word is read.
// - Self-clearing bits drop back to zero alone; writing zero does nothing.
// - Self-setting bits return to one alone; writing one does nothing.
// - Sticky-high read-only bits stay one until read, then follow condition.
// - Soft-reset-immune bits keep their value through a software reset.
// - Plain read-write bits store writes and read back the last value.
// - Read-write write-any-clear bits read their value and clear on write.
// - System registers are word registers at offsets 050h through 2DCh.
// - Both the two-wire port and the management port reach the bank.
// - A chip-level reset loads every register with its default.
// - Offsets 200h to 2DCh pass straight to the switch engine registers.
// - Offsets below 050h, above 2DCh and map gaps hold no register.
// - Write-one-clear bits clear on a one; a zero leaves them alone.
// - Read-only bits and words ignore writes and only report.
`timescale 1ns/1ps
`include "scrb_defines.svh"
module scrb_system_csr_bank #(
  parameter logic [31:0] CHIP_IDENT = 32'h0A5A_0001, // Arbitrary value
  parameter logic [31:0] BYTE_PATTERN = 32'h1234_5678,
  parameter logic [31:0] EPHY_IDENT_HI = 32'h0000_0ABC, // Arbitrary value
  parameter logic [31:0] EPHY_IDENT_LO = 32'h0000_1DE0, // Arbitrary value
  parameter int GIO_EVENTS = 12
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic i2cReq,
  input wire logic i2cWrite,
  input wire logic [`SCRB_ADDR_W-1:0] i2cAddr,
  input wire logic [31:0] i2cWdata,
  output logic i2cAck,
  output logic [31:0] i2cRdata,
  input wire logic smiReq,
  input wire logic smiWrite,
  input wire logic [`SCRB_ADDR_W-1:0] smiAddr,
  input wire logic [31:0] smiWdata,
  output logic smiAck,
  output logic [31:0] smiRdata,
  output logic fabricWr,
  output logic fabricRd,
  output logic [`SCRB_ADDR_W-1:0] fabricAddr,
  output logic [31:0] fabricWdata,
  input wire logic [31:0] fabricRdata,
  input wire logic [31:0] intSources,
  input wire logic deassertActive,
  input wire logic [GIO_EVENTS-1:0] gioEvents,
  input wire logic ephyLinkUp,
  input wire logic ephyRemoteFault,
  input wire logic ephyPageRx,
  input wire logic ephyPartnerEvent,
  output logic irqEnable,
  output logic irqActiveHigh,
  output logic irqPushPull,
  output logic [7:0] deassertInterval,
  output logic deassertClear,
  output logic irqMaster,
  output logic softReset
);
  localparam int NREG = `SCRB_NREG;

  if (GIO_EVENTS < 1 || GIO_EVENTS > 12)
  begin : g_bad_gio
    $error("scrb_system_csr_bank: GIO_EVENTS must be 1 to 12");
  end

  // Register indices
  localparam int I_ID = 0;
  localparam int I_IRQ = 1;
  localparam int I_STS = 2;
  localparam int I_EN = 3;
  localparam int I_BYTE = 4;
  localparam int I_FREE = 8;
  localparam int I_PMGMT_ACC = 10;
  localparam int I_FC0 = 13;
  localparam int I_ROM_CMD = 16;
  localparam int I_EPHY_CTRL = 19;
  localparam int I_EPHY_STAT = 20;
  localparam int I_EPHY_IDH = 21;
  localparam int I_EPHY_IDL = 22;
  localparam int I_EPHY_EXP = 25;
  localparam int I_GIO_EVT = 29;
  localparam int I_P1_CTRL = 30;
  localparam int I_RESET = 33;

  localparam logic [`SCRB_ADDR_W-1:0] OFFSET [NREG] = '{
    `SCRB_OFF_CHIP_IDENTITY_REVISION,
    `SCRB_OFF_IRQ_CFG,
    `SCRB_OFF_INTERRUPT_STATUS,
    `SCRB_OFF_INT_EN,
    `SCRB_OFF_BYTE_TEST,
    `SCRB_OFF_HARDWARE_CONFIG,
    `SCRB_OFF_GP_TIMER_CONFIG,
    `SCRB_OFF_GP_TIMER_COUNT,
    `SCRB_OFF_FREE_RUN,
    `SCRB_OFF_PMGMT_DATA,
    `SCRB_OFF_PMGMT_ACC,
    `SCRB_OFF_FC1,
    `SCRB_OFF_FC2,
    `SCRB_OFF_FC0,
    `SCRB_OFF_FAB_DATA,
    `SCRB_OFF_FAB_CMD,
    `SCRB_OFF_ROM_CMD,
    `SCRB_OFF_ROM_DATA,
    `SCRB_OFF_IND_CFG,
    `SCRB_OFF_EPHY_CTRL,
    `SCRB_OFF_EPHY_STAT,
    `SCRB_OFF_EPHY_IDH,
    `SCRB_OFF_EPHY_IDL,
    `SCRB_OFF_EPHY_ADV,
    `SCRB_OFF_EPHY_LPA,
    `SCRB_OFF_EPHY_EXP,
    `SCRB_OFF_EPHY_SPC,
    `SCRB_OFF_GIO_CFG,
    `SCRB_OFF_GIO_DIR,
    `SCRB_OFF_GIO_EVT,
    `SCRB_OFF_P1_CTRL,
    `SCRB_OFF_STA_HI,
    `SCRB_OFF_STA_LO,
    `SCRB_OFF_RESET_CONTROL
  };

  // Builds one attribute set from its masks
  function automatic scrb_pkg::scrb_attr_t mkAttr(
    input logic [31:0] rw,
    input logic [31:0] ro,
    input logic [31:0] write_any_clear,
    input logic [31:0] woc,
    input logic [31:0] rc,
    input logic [31:0] ll,
    input logic [31:0] lh,
    input logic [31:0] sc,
    input logic [31:0] ss,
    input logic [31:0] rolh,
    input logic [31:0] soft_reset_immune);
    scrb_pkg::scrb_attr_t a;
    a = '0;
    a.rw = rw;
    a.ro = ro;
    a.write_any_clear = write_any_clear;
    a.woc = woc;
    a.rc = rc;
    a.ll = ll;
    a.lh = lh;
    a.sc = sc;
    a.ss = ss;
    a.rolh = rolh;
    a.soft_reset_immune = soft_reset_immune;
    return a;
  endfunction : mkAttr

  // Attribute set of each register word
  function automatic scrb_pkg::scrb_attr_t regAttr(input int idx);
    scrb_pkg::scrb_attr_t a;
    a = mkAttr(`SCRB_ALL, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0);
    case (idx)
      I_ID, I_BYTE, I_FREE, I_EPHY_IDH, I_EPHY_IDL:
      begin
        a = mkAttr('0, `SCRB_ALL, '0, '0, '0, '0, '0, '0, '0, '0, '0);
      end
      I_IRQ:
      begin
        a = mkAttr(`SCRB_IRQCFG_RW, `SCRB_IRQCFG_RO, '0, '0, '0, '0, '0,
          `SCRB_IRQCFG_SC, '0, '0, `SCRB_IRQCFG_SOFT_RESET_IMMUNE);
      end
      I_STS:
      begin
        a = mkAttr('0, '0, '0, `SCRB_ALL, '0, '0, '0, '0, '0, '0, '0);
      end
      I_PMGMT_ACC, I_ROM_CMD, I_EPHY_CTRL, I_P1_CTRL:
      begin
        a = mkAttr(`SCRB_LOW15, '0, '0, '0, '0, '0, '0, `SCRB_BIT15, '0,
          '0, '0);
      end
      I_FC0:
      begin
        a = mkAttr(~`SCRB_BIT0, '0, '0, '0, '0, '0, '0, '0, `SCRB_BIT0,
          '0, '0);
      end
      I_EPHY_STAT:
      begin
        a = mkAttr('0, ~(`SCRB_EPHY_STAT_LL | `SCRB_EPHY_STAT_ROLH), '0,
          '0, '0, `SCRB_EPHY_STAT_LL, '0, '0, '0, `SCRB_EPHY_STAT_ROLH, '0);
      end
      I_EPHY_EXP:
      begin
        a = mkAttr('0, '0, '0, '0, `SCRB_EPHY_EXP_RC, '0,
          `SCRB_EPHY_EXP_LH, '0, '0, '0, '0);
      end
      I_GIO_EVT:
      begin
        a = mkAttr(`SCRB_GIO_EVT_RW, '0, `SCRB_GIO_EVT_WAC, '0, '0, '0, '0,
          '0, '0, '0, '0);
      end
      I_RESET:
      begin
        a = mkAttr('0, '0, '0, '0, '0, '0, '0, `SCRB_BIT0, '0, '0, '0);
      end
      default:
      begin
        a = mkAttr(`SCRB_ALL, '0, '0, '0, '0, '0, '0, '0, '0, '0, '0);
      end
    endcase
    return a;
  endfunction : regAttr

  // Window membership of a word address
  function automatic logic inWindow(input logic [`SCRB_ADDR_W-1:0] wa);
    return (wa >= `SCRB_WIN_LO) && (wa <= `SCRB_WIN_HI);
  endfunction : inWindow

  scrb_access_if acc ();

  scrb_access_arbiter u_arbiter (
    .core_clk(core_clk),
    .rst(rst),
    .i2cReq(i2cReq),
    .i2cWrite(i2cWrite),
    .i2cAddr(i2cAddr),
    .i2cWdata(i2cWdata),
    .i2cAck(i2cAck),
    .i2cRdata(i2cRdata),
    .smiReq(smiReq),
    .smiWrite(smiWrite),
    .smiAddr(smiAddr),
    .smiWdata(smiWdata),
    .smiAck(smiAck),
    .smiRdata(smiRdata),
    .bus(acc.arbiter)
  );

  // Low address bits are ignored: word access only
  wire [`SCRB_ADDR_W-1:0] wordAddr =
    {acc.addr[`SCRB_ADDR_W-1:2], 2'b00};
  wire winHit = acc.valid && inWindow(wordAddr);
  wire winRead = winHit && !acc.write;
  wire winWrite = winHit && acc.write;

  logic [NREG-1:0] regHit;
  logic [NREG-1:0] regWr;
  logic [NREG-1:0] regRd;
  logic [31:0] value [NREG];
  logic [31:0] hwIn [NREG];
  logic [31:0] regRdata;
  logic [31:0] freeCount;
  logic swResetPulse;

  for (genvar i = 0; i < NREG; i++)
  begin : g_reg
    assign regHit[i] = acc.valid && (wordAddr == OFFSET[i]);
    assign regWr[i] = regHit[i] && acc.write;
    assign regRd[i] = regHit[i] && !acc.write;
    scrb_reg_cell #(
      .ATTR(regAttr(i))
    ) u_cell (
      .core_clk(core_clk),
      .rst(rst),
      .swReset(swResetPulse),
      .wrEn(regWr[i]),
      .rdEn(regRd[i]),
      .wdata(acc.wdata),
      .hwIn(hwIn[i]),
      .value(value[i])
    );
  end

  // Master line ignores the output enable and the hold-off interval
  wire irqInt = |(value[I_STS] & value[I_EN]);

  always_comb
  begin
    for (int i = 0; i < NREG; i++)
    begin
      hwIn[i] = 32'h0000_0000;
    end
    hwIn[I_ID] = CHIP_IDENT;
    hwIn[I_BYTE] = BYTE_PATTERN;
    hwIn[I_FREE] = freeCount;
    hwIn[I_EPHY_IDH] = EPHY_IDENT_HI;
    hwIn[I_EPHY_IDL] = EPHY_IDENT_LO;
    hwIn[I_IRQ][`SCRB_IRQ_MASTER_BIT] = irqInt;
    hwIn[I_IRQ][`SCRB_IRQ_DEAS_STS_BIT] = deassertActive;
    hwIn[I_STS] = intSources;
    hwIn[I_EPHY_STAT][`SCRB_EPHY_LINK_BIT] = ephyLinkUp;
    hwIn[I_EPHY_STAT][`SCRB_EPHY_FAULT_BIT] = ephyRemoteFault;
    hwIn[I_EPHY_EXP][0] = ephyPartnerEvent;
    hwIn[I_EPHY_EXP][1] = ephyPageRx;
    hwIn[I_GIO_EVT][GIO_EVENTS-1:0] = gioEvents;
  end

  // Unmapped offsets read zero and take no write
  always_comb
  begin
    regRdata = 32'h0000_0000;
    for (int i = 0; i < NREG; i++)
    begin
      if (regHit[i])
      begin
        regRdata = value[i];
      end
    end
  end

  assign acc.rdata = winRead ? fabricRdata : regRdata;

  // Switch engine window passes straight through
  assign fabricWr = winWrite;
  assign fabricRd = winRead;
  assign fabricAddr = wordAddr - `SCRB_WIN_LO;
  assign fabricWdata = acc.wdata;

  // Free running counter
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      freeCount <= 32'h0000_0000;
    else
      freeCount <= freeCount + 32'h0000_0001;
  end

  // Software reset from the reset control word
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      swResetPulse <= 1'b0;
    else
      swResetPulse <= value[I_RESET][`SCRB_RSTCTL_SOFT_BIT];
  end

  assign softReset = swResetPulse;
  assign irqEnable = value[I_IRQ][`SCRB_IRQ_EN_BIT];
  assign irqActiveHigh = value[I_IRQ][`SCRB_IRQ_POL_BIT];
  assign irqPushPull = value[I_IRQ][`SCRB_IRQ_TYPE_BIT];
  assign deassertInterval = value[I_IRQ][31:`SCRB_IRQ_DEAS_LSB];
  assign deassertClear = value[I_IRQ][`SCRB_IRQ_DEAS_CLR_BIT];
  assign irqMaster = value[I_IRQ][`SCRB_IRQ_MASTER_BIT];
endmodule : scrb_system_csr_bank

// ### verification/scrb_bank_chk.sv
// Concurrent checks on the system register bank ports
`timescale 1ns/1ps
`include "scrb_defines.svh"
module scrb_bank_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic i2cReq,
  input wire logic i2cWrite,
  input wire logic [`SCRB_ADDR_W-1:0] i2cAddr,
  input wire logic [31:0] i2cWdata,
  input wire logic i2cAck,
  input wire logic [31:0] i2cRdata,
  input wire logic smiReq,
  input wire logic smiAck,
  input wire logic fabricWr,
  input wire logic fabricRd,
  input wire logic [`SCRB_ADDR_W-1:0] fabricAddr,
  input wire logic deassertClear,
  input wire logic softReset
);
  wire logic i2cTake;
  wire logic [9:0] i2cWord;
  assign i2cTake = i2cReq && !i2cAck;
  assign i2cWord = i2cAddr & 10'h3FC;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence ctl_write(logic [9:0] off, int b);
    i2cTake && i2cWrite && i2cWord == off && i2cWdata[b];
  endsequence
  ack_next_a:
    assert property (i2cTake |=> i2cAck)
    else $error("two-wire access not answered next cycle");
  ack_pulse_a:
    assert property (i2cAck |=> !i2cAck)
    else $error("two-wire ack longer than one cycle");
  smi_ack_a:
    assert property (smiReq && !smiAck |-> ##[1:2] smiAck)
    else $error("management access not answered in time");
  hole_read_a:
    assert property (i2cTake && !i2cWrite && i2cAddr < 10'h050
      |=> i2cRdata == 32'h0000_0000)
    else $error("reserved offset read not zero");
  win_write_a:
    assert property (i2cTake && i2cWrite && i2cWord >= `SCRB_WIN_LO &&
      i2cWord <= `SCRB_WIN_HI |-> fabricWr &&
      fabricAddr == i2cWord - `SCRB_WIN_LO)
    else $error("window write not passed to engine");
  no_fab_a:
    assert property (i2cTake && i2cAddr < `SCRB_WIN_LO
      |-> !fabricWr && !fabricRd)
    else $error("engine strobed outside window");
  deas_pulse_a:
    assert property (deassertClear |=> !deassertClear)
    else $error("interval clear pulse too long");
  deas_trig_a:
    assert property (ctl_write(`SCRB_OFF_IRQ_CFG, 14)
      |-> ##[1:3] deassertClear)
    else $error("interval clear not pulsed");
  soft_pulse_a:
    assert property (softReset |=> !softReset)
    else $error("software reset pulse too long");
  soft_trig_a:
    assert property (ctl_write(`SCRB_OFF_RESET_CONTROL, 0) |-> ##[1:3] softReset)
    else $error("software reset not pulsed");
endmodule : scrb_bank_chk

bind scrb_system_csr_bank scrb_bank_chk u_chk (.core_clk(core_clk),
  .rst(rst), .i2cReq(i2cReq), .i2cWrite(i2cWrite), .i2cAddr(i2cAddr),
  .i2cWdata(i2cWdata), .i2cAck(i2cAck), .i2cRdata(i2cRdata),
  .smiReq(smiReq), .smiAck(smiAck), .fabricWr(fabricWr),
  .fabricRd(fabricRd), .fabricAddr(fabricAddr),
  .deassertClear(deassertClear), .softReset(softReset));

// ### verification/scrb_fabric_model.sv
// Behavioural switch engine answering the direct data window
`timescale 1ns/1ps
`include "scrb_defines.svh"
module scrb_fabric_model (
  input wire logic core_clk,
  input wire logic fabricWr,
  input wire logic fabricRd,
  input wire logic [`SCRB_ADDR_W-1:0] fabricAddr,
  input wire logic [31:0] fabricWdata,
  output logic [31:0] fabricRdata
);
  logic [31:0] mem [64];
  wire logic [5:0] idx;
  assign idx = fabricAddr[7:2];
  // Unselected cycles show the inverse so stale data cannot pass
  assign fabricRdata = fabricRd ? mem[idx] : ~mem[idx];
  always_ff @(posedge core_clk)
  begin
    if (fabricWr)
      mem[idx] <= fabricWdata;
  end
endmodule : scrb_fabric_model

// ### verification/system_csr_register_bank_tb.sv
// Self-checking bench for the system register bank
`timescale 1ns/1ps
`include "scrb_defines.svh"
module system_csr_register_bank_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] req = 2'b00;
  logic [1:0] wr = 2'b00;
  logic [1:0] ack;
  logic [9:0] addr [2] = '{10'h000, 10'h000};
  logic [31:0] wd [2] = '{32'h0, 32'h0};
  logic [31:0] rd [2];
  logic fWr, fRd, deasClr, irqEn, irqHigh, irqPp, irqMst, softRst;
  logic [9:0] fAddr;
  logic [31:0] fWd, fRd32;
  logic [7:0] deasInt;
  logic [31:0] intSources = 32'h0;
  logic deassertActive = 1'b0;
  logic [11:0] gioEvents = 12'h000;
  logic linkUp = 1'b1, fault = 1'b0, pageRx = 1'b0, lpEvt = 1'b0;
  int errCount = 0;
  int checksDone = 0;

  always #50 core_clk = ~core_clk;

  scrb_system_csr_bank u_dut (.core_clk(core_clk), .rst(rst),
    .i2cReq(req[0]), .i2cWrite(wr[0]), .i2cAddr(addr[0]),
    .i2cWdata(wd[0]), .i2cAck(ack[0]), .i2cRdata(rd[0]),
    .smiReq(req[1]), .smiWrite(wr[1]), .smiAddr(addr[1]),
    .smiWdata(wd[1]), .smiAck(ack[1]), .smiRdata(rd[1]),
    .fabricWr(fWr), .fabricRd(fRd), .fabricAddr(fAddr),
    .fabricWdata(fWd), .fabricRdata(fRd32), .intSources(intSources),
    .deassertActive(deassertActive), .gioEvents(gioEvents),
    .ephyLinkUp(linkUp), .ephyRemoteFault(fault), .ephyPageRx(pageRx),
    .ephyPartnerEvent(lpEvt), .irqEnable(irqEn), .irqActiveHigh(irqHigh),
    .irqPushPull(irqPp), .deassertInterval(deasInt),
    .deassertClear(deasClr), .irqMaster(irqMst), .softReset(softRst));

  scrb_fabric_model u_fab (.core_clk(core_clk), .fabricWr(fWr),
    .fabricRd(fRd), .fabricAddr(fAddr), .fabricWdata(fWd),
    .fabricRdata(fRd32));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One word access on port p, held until its ack
  task automatic acc(input int p, input logic w, input logic [9:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(negedge core_clk);
    req[p] = 1'b1;
    wr[p] = w;
    addr[p] = a;
    wd[p] = d;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (ack[p] !== 1'b1 && n < 20);
    chk({31'h0, ack[p]}, 32'h1);
    r = rd[p];
    @(negedge core_clk);
    req[p] = 1'b0;
    addr[p] = ~a;
    wd[p] = ~d;
  endtask : acc

  task automatic wreg(input int p, input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(p, 1'b1, a, d, r);
  endtask : wreg

  task automatic rdchk(input int p, input logic [9:0] a,
    input logic [31:0] e);
    logic [31:0] r;
    acc(p, 1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rdchk

  task automatic t_rw();
    wreg(0, `SCRB_OFF_INT_EN, 32'hA5A5_5A5A);
    rdchk(1, `SCRB_OFF_INT_EN, 32'hA5A5_5A5A);
    wreg(1, 10'h05F, 32'h0000_00F0);
    rdchk(0, `SCRB_OFF_INT_EN, 32'h0000_00F0);
    wreg(1, `SCRB_OFF_BYTE_TEST, 32'h0);
    rdchk(0, `SCRB_OFF_BYTE_TEST, 32'h1234_5678);
    fork
      wreg(0, `SCRB_OFF_STA_HI, 32'h0000_1111);
      wreg(1, `SCRB_OFF_STA_LO, 32'h2222_3333);
    join
    rdchk(1, `SCRB_OFF_STA_HI, 32'h0000_1111);
    rdchk(0, `SCRB_OFF_STA_LO, 32'h2222_3333);
  endtask : t_rw

  task automatic t_holes();
    logic [9:0] h [6] = '{10'h000, 10'h04C, 10'h060, 10'h1FC, 10'h2E0,
      10'h3FC};
    foreach (h[i])
    begin
      wreg(1, h[i], `SCRB_ALL);
      rdchk(0, h[i], 32'h0);
    end
  endtask : t_holes

  task automatic t_window();
    wreg(1, 10'h204, 32'hCAFE_0001);
    wreg(0, `SCRB_WIN_HI, 32'hCAFE_00DC);
    rdchk(0, 10'h204, 32'hCAFE_0001);
    rdchk(1, `SCRB_WIN_HI, 32'hCAFE_00DC);
  endtask : t_window

  task automatic t_events();
    @(negedge core_clk);
    intSources = 32'h0000_0009;
    gioEvents = 12'h021;
    lpEvt = 1'b1;
    pageRx = 1'b1;
    @(negedge core_clk);
    intSources = 32'h0;
    gioEvents = 12'h000;
    lpEvt = 1'b0;
    pageRx = 1'b0;
    wreg(1, `SCRB_OFF_INTERRUPT_STATUS, 32'h0000_0001);
    rdchk(0, `SCRB_OFF_INTERRUPT_STATUS, 32'h0000_0008);
    wreg(1, `SCRB_OFF_INTERRUPT_STATUS, 32'h0000_0000);
    rdchk(0, `SCRB_OFF_INTERRUPT_STATUS, 32'h0000_0008);
    wreg(1, `SCRB_OFF_INT_EN, 32'h0000_0008);
    @(negedge core_clk);
    chk({31'h0, irqMst}, 32'h1);
    wreg(0, `SCRB_OFF_INTERRUPT_STATUS, `SCRB_ALL);
    @(negedge core_clk);
    chk({31'h0, irqMst}, 32'h0);
    rdchk(0, `SCRB_OFF_GIO_EVT, 32'h0000_0021);
    wreg(0, `SCRB_OFF_GIO_EVT, 32'h0ABC_0000);
    rdchk(1, `SCRB_OFF_GIO_EVT, 32'h0ABC_0000);
    wreg(1, `SCRB_OFF_EPHY_EXP, 32'h0);
    rdchk(0, `SCRB_OFF_EPHY_EXP, 32'h0000_0003);
    rdchk(0, `SCRB_OFF_EPHY_EXP, 32'h0000_0000);
  endtask : t_events

  task automatic t_phy();
    rdchk(1, `SCRB_OFF_EPHY_STAT, 32'h0000_0000);
    rdchk(1, `SCRB_OFF_EPHY_STAT, 32'h0000_0004);
    @(negedge core_clk);
    linkUp = 1'b0;
    fault = 1'b1;
    @(negedge core_clk);
    linkUp = 1'b1;
    fault = 1'b0;
    rdchk(1, `SCRB_OFF_EPHY_STAT, 32'h0000_0010);
    rdchk(1, `SCRB_OFF_EPHY_STAT, 32'h0000_0004);
    fault = 1'b1;
    rdchk(0, `SCRB_OFF_EPHY_STAT, 32'h0000_0014);
    rdchk(0, `SCRB_OFF_EPHY_STAT, 32'h0000_0014);
  endtask : t_phy

  task automatic t_self();
    wreg(0, `SCRB_OFF_ROM_CMD, 32'h0000_8001);
    rdchk(0, `SCRB_OFF_ROM_CMD, 32'h0000_0001);
    wreg(0, `SCRB_OFF_FC0, 32'h0000_0010);
    rdchk(1, `SCRB_OFF_FC0, 32'h0000_0011);
    deassertActive = 1'b1;
    wreg(0, `SCRB_OFF_IRQ_CFG, 32'h0000_4000);
    rdchk(0, `SCRB_OFF_IRQ_CFG, 32'h0000_2000);
    deassertActive = 1'b0;
  endtask : t_self

  task automatic t_soft();
    int n;
    n = 0;
    wreg(0, `SCRB_OFF_IRQ_CFG, 32'h0300_0111);
    @(negedge core_clk);
    chk({21'h0, irqEn, irqHigh, irqPp, deasInt}, 32'h0000_0703);
    wreg(0, `SCRB_OFF_RESET_CONTROL, 32'h0000_0001);
    while (softRst !== 1'b1 && n < 10)
    begin
      @(negedge core_clk);
      n++;
    end
    chk({31'h0, softRst}, 32'h1);
    @(negedge core_clk);
    rdchk(0, `SCRB_OFF_IRQ_CFG, 32'h0000_0011);
    rdchk(1, `SCRB_OFF_INT_EN, 32'h0);
    rdchk(1, `SCRB_OFF_RESET_CONTROL, 32'h0);
  endtask : t_soft

  task automatic t_chip();
    wreg(1, `SCRB_OFF_STA_LO, 32'h1357_9BDF);
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    rdchk(0, `SCRB_OFF_STA_LO, 32'h0);
    rdchk(1, `SCRB_OFF_IRQ_CFG, 32'h0);
  endtask : t_chip

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (20000) @(posedge core_clk);
    errCount++;
    tally_and_finish();
  end

  initial
  begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    t_rw();
    t_holes();
    t_window();
    t_events();
    t_phy();
    t_self();
    t_soft();
    t_chip();
    tally_and_finish();
  end
endmodule : system_csr_register_bank_tb
